/* bench/absolute_move_command_test.sv */
`timescale 1ns/100ps
module absolute_move_command_test;
    import abs_move_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, ev = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic target_reached, axis_taken_over, axis_fault, move_run, irq;
    logic [15:0] axis_fault_code, code = 16'hA5C3;
    move_cmd_t move_cmd;
    move_status_t move_status;
    wire logic [2:0] flags = {move_status.done, move_status.aborted_flag, move_status.error};
    int bad_count = 0, samples_checked = 0;

    absolute_move_command i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .target_reached, .axis_taken_over,
        .axis_fault, .axis_fault_code, .move_cmd, .move_run, .move_status, .irq);
    traj_model i_engine (.move_run, .ev, .code, .target_reached, .axis_taken_over, .axis_fault,
        .axis_fault_code);
    initial forever #12.5 aclk = ~aclk;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [31:0] dat);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // One move: lo drops the start request before the end event arrives.
    task automatic run(input bit rot, input logic [31:0] pos, vel, input logic [2:0] dir, bm,
            input logic [1:0] e, input bit lo);
        logic [15:0] ec;
        logic [2:0] fl;
        ec = 16'h0;
        if ($signed(vel) < 1) ec = ERR_PARAM_NOT_POSITIVE;
        else if (rot && (pos[31] ? -pos : pos) >= 32'h168) ec = ERR_POSITION_RANGE;
        else if (rot && (dir < 3'h1 || dir > 3'h4)) ec = ERR_BAD_DIRECTION;
        else if (bm > 3'h5) ec = ERR_BAD_BUFFER_MODE;
        fl = ec != 16'h0 ? 3'h1 : 3'h4 >> (e - 2'h1);
        wr(OFS_POS, pos);
        wr(OFS_VEL, vel);
        wr(OFS_MODE, {25'h0, bm, 1'h0, dir});
        wr(OFS_CTRL, {30'h0, rot, 1'h1});
        for (int n = 0; n < 8 && move_status.busy !== 1'h1; n++) @(posedge aclk);
        chk(move_status.busy, 1'h1);
        @(posedge aclk);
        chk({move_status.active, move_run}, {2{ec == 16'h0}});
        chk(move_status.error_code, ec);
        chk({move_cmd.position, move_cmd.velocity}, {pos, vel});
        chk({move_cmd.direction, move_cmd.buffering_mode}, {dir, bm});
        if (ec == 16'h0) begin
            wr(OFS_POS, ~pos);
            wr(OFS_CTRL, {30'h0, rot, 1'h0});
            wr(OFS_CTRL, {30'h0, rot, !lo});
            chk({move_status.busy, move_cmd.position}, {1'h1, pos});
            ev <= e;
        end
        for (int n = 0; n < 12 && flags == 3'h0; n++) @(posedge aclk);
        ev <= 2'h0;
        chk({flags, move_status.busy, move_status.active}, {fl, 2'h0});
        @(posedge aclk);
        chk(flags, lo ? 3'h0 : fl);
        if (e == 2'h2 && ec == 16'h0) chk(move_cmd.position, 32'h0);
        if (e == 2'h3) chk(move_status.error_code, code);
        wr(OFS_CTRL, 32'h0);
        for (int n = 0; n < 6 && flags != 3'h0; n++) @(posedge aclk);
        chk(flags, 3'h0);
    endtask : run

    initial begin
        void'($urandom(27));
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(OFS_MODE);
        chk(d, 32'h1);
        rd(6'h30);
        chk({r, d}, {RESP_SLVERR, 32'h0});
        wr(OFS_AXIS, 32'h1);
        wr(OFS_MODULO, 32'h168);
        wr(OFS_ACC, 32'h10);
        wr(OFS_DEC, 32'h10);
        wr(OFS_JERK, 32'h10);
        chk(r, RESP_OKAY);
        wr(6'h30, 32'h1);
        chk(r, RESP_SLVERR);
        run(1'h0, $urandom, $urandom >> 1 | 32'h1, 3'h1, 3'h0, 2'h1, 1'h0);
        chk(irq, 1'h0);
        wr(OFS_IRQ_MASK, 32'h7);
        repeat (2) @(posedge aclk);
        chk(irq, 1'h1);
        rd(OFS_IRQ_STAT);
        chk(d, 32'h1);
        wr(OFS_IRQ_STAT, 32'h7);
        repeat (2) @(posedge aclk);
        chk(irq, 1'h0);
        for (int k = 0; k < 6; k++)
            run(1'h1, 32'(k * 50), 32'h40, 3'(k % 4 + 1), 3'(k), 2'(k % 2 + 1), k[1]);
        run(1'h0, $urandom, 32'h0, 3'h1, 3'h0, 2'h1, 1'h0);
        run(1'h1, 32'h168, 32'h40, 3'h2, 3'h0, 2'h1, 1'h0);
        run(1'h1, 32'hFFFFFE98, 32'h40, 3'h3, 3'h1, 2'h1, 1'h0);
        run(1'h1, 32'h10, 32'h40, 3'h5, 3'h0, 2'h1, 1'h0);
        run(1'h0, 32'h10, 32'h40, 3'h0, 3'h6, 2'h1, 1'h0);
        code <= 16'($urandom);
        run(1'h0, $urandom, 32'h40, 3'h7, 3'h0, 2'h3, 1'h0);
        wrap_up();
    end
    initial begin
        #500us;
        bad_count++;
        wrap_up();
    end
endmodule : absolute_move_command_test

/* bench/traj_model.sv */
`timescale 1ns/100ps
module traj_model (
    // Event request from the bench and the move's hold on the axis
    input wire logic move_run,
    input wire logic [1:0] ev,
    input wire logic [15:0] code,
    // Engine pins
    output logic target_reached,
    output logic axis_taken_over,
    output logic axis_fault,
    output logic [15:0] axis_fault_code
);
    // Events show only while the move owns the axis, so none can leak into the next move.
    assign target_reached = ev == 2'h1 && move_run;
    assign axis_taken_over = ev == 2'h2 && move_run;
    assign axis_fault = ev == 2'h3 && move_run;
    // The code means something only beside the fault; otherwise it shows its inverse.
    assign axis_fault_code = axis_fault ? code : ~code;
endmodule : traj_model

/* rtl/abs_move_pkg.sv */
package abs_move_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_AXIS = 6'h04;
    localparam logic [5:0] OFS_POS = 6'h08;
    localparam logic [5:0] OFS_VEL = 6'h0C;
    localparam logic [5:0] OFS_ACC = 6'h10;
    localparam logic [5:0] OFS_DEC = 6'h14;
    localparam logic [5:0] OFS_JERK = 6'h18;
    localparam logic [5:0] OFS_MODE = 6'h1C;
    localparam logic [5:0] OFS_MODULO = 6'h20;
    localparam logic [5:0] OFS_STATUS = 6'h24;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h28;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h2C;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_EXEC_BIT = 0;
    localparam int CTRL_ROTARY_BIT = 1;
    localparam int MODE_DIR_LSB = 0;
    localparam int MODE_BUF_LSB = 4;
    localparam int STAT_CODE_LSB = 16;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int IRQ_ERROR_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        DIR_POSITIVE = 3'h1,
        DIR_SHORTEST = 3'h2,
        DIR_NEGATIVE = 3'h3,
        DIR_KEEP_CURRENT = 3'h4
    } direction_t;

    typedef enum logic [2:0] {
        MODE_ABORT_PREVIOUS = 3'h0,
        MODE_QUEUE_AFTER = 3'h1,
        MODE_BLEND_LOW = 3'h2,
        MODE_BLEND_PREV = 3'h3,
        MODE_BLEND_NEXT = 3'h4,
        MODE_BLEND_HIGH = 3'h5
    } buffering_mode_t;

    localparam direction_t DIR_RESET = DIR_POSITIVE;
    localparam buffering_mode_t MODE_RESET = MODE_ABORT_PREVIOUS;

    localparam logic [15:0] ERR_POSITION_RANGE = 16'h0001;
    localparam logic [15:0] ERR_PARAM_NOT_POSITIVE = 16'h0002;
    localparam logic [15:0] ERR_BAD_DIRECTION = 16'h0003;
    localparam logic [15:0] ERR_BAD_BUFFER_MODE = 16'h0004;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b011,
        ST_ABORTED = 3'b100,
        ST_ERROR = 3'b101
    } move_state_t;

    // Parameters of one move as handed to the trajectory engine.
    typedef struct packed {
        logic [7:0] axis;
        logic [31:0] position;
        logic [31:0] velocity;
        logic [31:0] acceleration;
        logic [31:0] deceleration;
        logic [31:0] jerk;
        direction_t direction;
        buffering_mode_t buffering_mode;
        logic rotary;
    } move_cmd_t;

    // Handshake outputs of the move command.
    typedef struct packed {
        logic done;
        logic busy;
        logic active;
        logic aborted_flag;
        logic error;
        logic [15:0] error_code;
    } move_status_t;

endpackage : abs_move_pkg

/* rtl/absolute_move_command.sv */
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module absolute_move_command
    import abs_move_pkg::*;
#(
    parameter int AXIS_COUNT = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Trajectory engine pins, asynchronous to aclk
    input wire logic target_reached,
    input wire logic axis_taken_over,
    input wire logic axis_fault,
    input wire logic [15:0] axis_fault_code,
    // Move towards the trajectory engine and status
    output move_cmd_t move_cmd,
    output logic move_run,
    output move_status_t move_status,
    output logic irq
);

    // The axis field is eight bits wide, so no more than 256 axes can be addressed.
    if (AXIS_COUNT < 1 || AXIS_COUNT > 256) begin : g_bad_axis_count
        $error("AXIS_COUNT must lie between 1 and 256");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [5:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic exec;
        logic rotary;
        move_cmd_t regs;
        logic [31:0] modulo;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic exec_d;
        move_state_t st;
        move_cmd_t cmd;
        logic run;
        move_status_t stat;
        logic irq;
        logic reach_s1;
        logic reach_s2;
        logic take_s1;
        logic take_s2;
        logic fault_s1;
        logic fault_s2;
        logic [15:0] code_s1;
        logic [15:0] code_s2;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic [31:0] magnitude(input logic [31:0] v);
        return v[31] ? 32'(-v) : v;
    endfunction : magnitude

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [31:0] wval;
    logic [31:0] status_word;
    logic exec_rise;
    logic [15:0] check_code;

    always_comb begin
        nxt_cur = cur_ff;
        wval = 32'h0000_0000;
        status_word = 32'h0000_0000;
        exec_rise = cur_ff.exec && !cur_ff.exec_d;
        check_code = 16'h0000;

        // The first stage of each synchroniser feeds only its second stage.
        nxt_cur.reach_s1 = target_reached;
        nxt_cur.reach_s2 = cur_ff.reach_s1;
        nxt_cur.take_s1 = axis_taken_over;
        nxt_cur.take_s2 = cur_ff.take_s1;
        nxt_cur.fault_s1 = axis_fault;
        nxt_cur.fault_s2 = cur_ff.fault_s1;
        nxt_cur.code_s1 = axis_fault_code;
        nxt_cur.code_s2 = cur_ff.code_s1;
        nxt_cur.exec_d = cur_ff.exec;

        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && cur_ff.awready) begin
            nxt_cur.aw_got = 1'b1;
            nxt_cur.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && cur_ff.wready) begin
            nxt_cur.w_got = 1'b1;
            nxt_cur.wdata = s_axi_wdata;
            nxt_cur.wstrb = s_axi_wstrb;
        end
        if (cur_ff.bvalid && s_axi_bready) begin
            nxt_cur.bvalid = 1'b0;
        end
        if (cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid) begin
            nxt_cur.aw_got = 1'b0;
            nxt_cur.w_got = 1'b0;
            nxt_cur.bvalid = 1'b1;
            nxt_cur.bresp = RESP_OKAY;
            case ({cur_ff.awaddr[5:2], 2'b00})
                OFS_CTRL: begin
                    wval = merge({30'h0, cur_ff.rotary, cur_ff.exec}, cur_ff.wdata,
                                 cur_ff.wstrb);
                    nxt_cur.exec = wval[CTRL_EXEC_BIT];
                    nxt_cur.rotary = wval[CTRL_ROTARY_BIT];
                end
                OFS_AXIS: begin
                    wval = merge({24'h0, cur_ff.regs.axis}, cur_ff.wdata, cur_ff.wstrb);
                    nxt_cur.regs.axis = wval[7:0];
                end
                OFS_POS: nxt_cur.regs.position = merge(cur_ff.regs.position, cur_ff.wdata,
                                                       cur_ff.wstrb);
                OFS_VEL: nxt_cur.regs.velocity = merge(cur_ff.regs.velocity, cur_ff.wdata,
                                                       cur_ff.wstrb);
                OFS_ACC: nxt_cur.regs.acceleration = merge(cur_ff.regs.acceleration,
                                                           cur_ff.wdata, cur_ff.wstrb);
                OFS_DEC: nxt_cur.regs.deceleration = merge(cur_ff.regs.deceleration,
                                                           cur_ff.wdata, cur_ff.wstrb);
                OFS_JERK: nxt_cur.regs.jerk = merge(cur_ff.regs.jerk, cur_ff.wdata,
                                                    cur_ff.wstrb);
                OFS_MODE: begin
                    wval = merge({25'h0, cur_ff.regs.buffering_mode, 1'b0,
                                  cur_ff.regs.direction}, cur_ff.wdata, cur_ff.wstrb);
                    nxt_cur.regs.direction = direction_t'(wval[MODE_DIR_LSB +: 3]);
                    nxt_cur.regs.buffering_mode = buffering_mode_t'(wval[MODE_BUF_LSB +: 3]);
                end
                OFS_MODULO: nxt_cur.modulo = merge(cur_ff.modulo, cur_ff.wdata, cur_ff.wstrb);
                OFS_IRQ_STAT: begin
                    // Write one to clear; a new event in the same cycle is set again below.
                    if (cur_ff.wstrb[0]) begin
                        nxt_cur.irq_stat = cur_ff.irq_stat & ~cur_ff.wdata[2:0];
                    end
                end
                OFS_IRQ_MASK: begin
                    if (cur_ff.wstrb[0]) begin
                        nxt_cur.irq_mask = cur_ff.wdata[2:0];
                    end
                end
                OFS_STATUS: nxt_cur.bresp = RESP_OKAY;
                default: nxt_cur.bresp = RESP_SLVERR;
            endcase
        end
        nxt_cur.awready = !nxt_cur.aw_got && !nxt_cur.bvalid;
        nxt_cur.wready = !nxt_cur.w_got && !nxt_cur.bvalid;

        // Read channel.
        status_word = {cur_ff.stat.error_code, 11'h000, cur_ff.stat.error,
                       cur_ff.stat.aborted_flag, cur_ff.stat.active, cur_ff.stat.busy,
                       cur_ff.stat.done};
        if (cur_ff.rvalid && s_axi_rready) begin
            nxt_cur.rvalid = 1'b0;
        end
        if (s_axi_arvalid && cur_ff.arready) begin
            nxt_cur.rvalid = 1'b1;
            nxt_cur.rresp = RESP_OKAY;
            case ({s_axi_araddr[5:2], 2'b00})
                OFS_CTRL: nxt_cur.rdata = {30'h0, cur_ff.rotary, cur_ff.exec};
                OFS_AXIS: nxt_cur.rdata = {24'h0, cur_ff.regs.axis};
                OFS_POS: nxt_cur.rdata = cur_ff.regs.position;
                OFS_VEL: nxt_cur.rdata = cur_ff.regs.velocity;
                OFS_ACC: nxt_cur.rdata = cur_ff.regs.acceleration;
                OFS_DEC: nxt_cur.rdata = cur_ff.regs.deceleration;
                OFS_JERK: nxt_cur.rdata = cur_ff.regs.jerk;
                OFS_MODE: nxt_cur.rdata = {25'h0, cur_ff.regs.buffering_mode, 1'b0,
                                           cur_ff.regs.direction};
                OFS_MODULO: nxt_cur.rdata = cur_ff.modulo;
                OFS_STATUS: nxt_cur.rdata = status_word;
                OFS_IRQ_STAT: nxt_cur.rdata = {29'h0, cur_ff.irq_stat};
                OFS_IRQ_MASK: nxt_cur.rdata = {29'h0, cur_ff.irq_mask};
                default: begin
                    nxt_cur.rdata = 32'h0000_0000;
                    nxt_cur.rresp = RESP_SLVERR;
                end
            endcase
        end
        nxt_cur.arready = !nxt_cur.rvalid;

        // Parameter check of the captured move.
        if (cur_ff.cmd.velocity[31] || cur_ff.cmd.velocity == 32'h0 ||
            cur_ff.cmd.acceleration[31] || cur_ff.cmd.acceleration == 32'h0 ||
            cur_ff.cmd.deceleration[31] || cur_ff.cmd.deceleration == 32'h0 ||
            cur_ff.cmd.jerk[31] || cur_ff.cmd.jerk == 32'h0 ||
            32'(cur_ff.cmd.axis) >= 32'(AXIS_COUNT)) begin
            check_code = ERR_PARAM_NOT_POSITIVE;
        end else if (cur_ff.cmd.rotary &&
                     magnitude(cur_ff.cmd.position) >= cur_ff.modulo) begin
            check_code = ERR_POSITION_RANGE;
        end else if (cur_ff.cmd.rotary && (cur_ff.cmd.direction < DIR_POSITIVE ||
                     cur_ff.cmd.direction > DIR_KEEP_CURRENT)) begin
            check_code = ERR_BAD_DIRECTION;
        end else if (cur_ff.cmd.buffering_mode > MODE_BLEND_HIGH) begin
            check_code = ERR_BAD_BUFFER_MODE;
        end

        // ----------------------------------------------------------------
        // Move sequencer
        // ----------------------------------------------------------------
        case (cur_ff.st)
            ST_IDLE: begin
                if (exec_rise) begin
                    nxt_cur.cmd = cur_ff.regs;
                    nxt_cur.cmd.rotary = cur_ff.rotary;
                    nxt_cur.st = ST_START;
                    nxt_cur.stat.busy = 1'b1;
                end
            end
            ST_START: begin
                // Rises and falls of the start request are not looked at here.
                if (check_code != 16'h0000) begin
                    nxt_cur.st = ST_ERROR;
                    nxt_cur.stat.busy = 1'b0;
                    nxt_cur.stat.error = 1'b1;
                    nxt_cur.stat.error_code = check_code;
                end else begin
                    nxt_cur.st = ST_RUN;
                    nxt_cur.stat.active = 1'b1;
                    nxt_cur.run = 1'b1;
                end
            end
            ST_RUN: begin
                if (cur_ff.fault_s2) begin
                    nxt_cur.st = ST_ERROR;
                    nxt_cur.stat.error = 1'b1;
                    nxt_cur.stat.error_code = cur_ff.code_s2;
                end else if (cur_ff.take_s2) begin
                    nxt_cur.st = ST_ABORTED;
                    nxt_cur.stat.aborted_flag = 1'b1;
                    nxt_cur.cmd.position = 32'h0000_0000;
                end else if (cur_ff.reach_s2) begin
                    nxt_cur.st = ST_DONE;
                    nxt_cur.stat.done = 1'b1;
                end
                if (cur_ff.fault_s2 || cur_ff.take_s2 || cur_ff.reach_s2) begin
                    nxt_cur.stat.busy = 1'b0;
                    nxt_cur.stat.active = 1'b0;
                    nxt_cur.run = 1'b0;
                end
            end
            ST_DONE, ST_ABORTED, ST_ERROR: begin
                // A low start request ends the flag, at once or after one period.
                if (!cur_ff.exec) begin
                    nxt_cur.st = ST_IDLE;
                    nxt_cur.stat.done = 1'b0;
                    nxt_cur.stat.aborted_flag = 1'b0;
                    nxt_cur.stat.error = 1'b0;
                    nxt_cur.stat.error_code = 16'h0000;
                end
            end
            default: begin
                nxt_cur.st = ST_IDLE;
            end
        endcase

        // Sticky events win over a clear written in the same cycle.
        if (nxt_cur.stat.done && !cur_ff.stat.done) begin
            nxt_cur.irq_stat[IRQ_DONE_BIT] = 1'b1;
        end
        if (nxt_cur.stat.aborted_flag && !cur_ff.stat.aborted_flag) begin
            nxt_cur.irq_stat[IRQ_ABORT_BIT] = 1'b1;
        end
        if (nxt_cur.stat.error && !cur_ff.stat.error) begin
            nxt_cur.irq_stat[IRQ_ERROR_BIT] = 1'b1;
        end
        nxt_cur.irq = |(nxt_cur.irq_stat & nxt_cur.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_ff <= '0;
            cur_ff.regs.direction <= DIR_RESET;
            cur_ff.regs.buffering_mode <= MODE_RESET;
            cur_ff.cmd.direction <= DIR_RESET;
            cur_ff.cmd.buffering_mode <= MODE_RESET;
            cur_ff.st <= ST_IDLE;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = cur_ff.awready;
    assign s_axi_wready = cur_ff.wready;
    assign s_axi_bvalid = cur_ff.bvalid;
    assign s_axi_bresp = cur_ff.bresp;
    assign s_axi_arready = cur_ff.arready;
    assign s_axi_rvalid = cur_ff.rvalid;
    assign s_axi_rresp = cur_ff.rresp;
    assign s_axi_rdata = cur_ff.rdata;
    assign move_cmd = cur_ff.cmd;
    assign move_run = cur_ff.run;
    assign move_status = cur_ff.stat;
    assign irq = cur_ff.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_START_ON_RISE: assert property ($rose(move_status.busy) |->
        $past(cur_ff.exec) && !$past(cur_ff.exec_d)) else $error("busy rose without a rise");
    AST_RISE_IGNORED: assert property (cur_ff.st == ST_RUN && exec_rise && !cur_ff.take_s2
        |=> $stable(move_cmd)) else $error("move changed on a repeated rise");
    AST_CAPTURE: assert property ($rose(move_status.busy) |->
        move_cmd.velocity == $past(cur_ff.regs.velocity)) else $error("parameters not captured");
    AST_ROTARY_RANGE: assert property (cur_ff.st == ST_START && cur_ff.cmd.rotary &&
        magnitude(cur_ff.cmd.position) >= cur_ff.modulo |=> move_status.error)
        else $error("rotary range not refused");
    AST_DONE_ON_REACH: assert property (cur_ff.st == ST_RUN && cur_ff.reach_s2 &&
        !cur_ff.fault_s2 && !cur_ff.take_s2 |=> move_status.done) else $error("done missing");
    AST_DONE_ONE_PERIOD: assert property ($rose(move_status.done) && !cur_ff.exec |=>
        !move_status.done) else $error("done held too long");
    AST_BUSY_DROP: assert property ($rose(move_status.done) || $rose(move_status.error) ||
        $rose(move_status.aborted_flag) |-> !move_status.busy && !move_status.active)
        else $error("busy or active left high");
    AST_ACTIVE_LATE: assert property ($rose(move_status.busy) |=> move_status.active ||
        move_status.error) else $error("active late");
    AST_ABORT_CLEAR: assert property (move_status.aborted_flag && cur_ff.exec |=>
        move_status.aborted_flag) else $error("aborted cleared early");
    AST_ERROR_HOLD: assert property (move_status.error && cur_ff.exec |=>
        move_status.error && $stable(move_status.error_code))
        else $error("error dropped early");
    AST_DISCARD: assert property ($rose(move_status.aborted_flag) |->
        !move_run && move_cmd.position == 32'h0) else $error("remaining move kept");
    AST_EXCLUSIVE: assert property ($onehot0({move_status.done, move_status.error,
        move_status.aborted_flag}) && !(move_status.busy && (move_status.done ||
        move_status.error || move_status.aborted_flag))) else $error("flags overlap");

endmodule : absolute_move_command
